// ---- rtl/psr_pkg.sv ----
// shared constants for the production signature readout bank
// assumes one 20 MHz clock, byte-wide register port, byte-wide fuse array
package psr_pkg;

    localparam int ADDR_W      = 6;            // register and fuse address width
    localparam int DATA_W      = 8;            // byte-wide data
    localparam int ENTRY_COUNT = 14;           // bytes held by the bank
    localparam int IDX_W       = 4;            // index into the bank
    localparam int SERIAL_W    = 40;           // wafer + X + Y

    // bank offsets, in entry order
    localparam logic [ADDR_W-1:0] SIG_OFFS [0:ENTRY_COUNT-1] = '{
        6'h10, 6'h12, 6'h13, 6'h14, 6'h15, 6'h1A, 6'h1B,
        6'h1C, 6'h20, 6'h21, 6'h24, 6'h25, 6'h2E, 6'h2F
    };

    // bits that exist in each byte; the others read as zero
    localparam logic [DATA_W-1:0] SIG_MASK [0:ENTRY_COUNT-1] = '{
        8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F
    };

    // entry indexes used to build the serial identity
    localparam int IDX_WAFER = 0;
    localparam int IDX_X_LO  = 1;
    localparam int IDX_X_HI  = 2;
    localparam int IDX_Y_LO  = 3;
    localparam int IDX_Y_HI  = 4;
    localparam logic [IDX_W-1:0] IDX_LAST = 4'hD;

    // control and status registers beside the bank
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 6'h3E;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h3F;
    localparam int CTRL_RELOAD  = 0;           // restart the fuse load
    localparam int CTRL_CLR_WR  = 1;           // clear write-ignored flag
    localparam int CTRL_CLR_MAP = 2;           // clear unmapped flag
    localparam int ST_DONE      = 0;
    localparam int ST_WR_IGN    = 1;
    localparam int ST_UNMAP     = 2;
    localparam int ST_BUSY      = 3;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

    // timing of the fuse array read
    localparam int CLK_PERIOD_NS  = 50;
    localparam int FUSE_ACCESS_NS = 100;
    localparam int SYNC_STAGES    = 2;
    localparam int FUSE_WAIT_CYC  = (FUSE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOAD_WAIT_CYC  = FUSE_WAIT_CYC + SYNC_STAGES;
    localparam int WAIT_W         = 4;

    // load sequencer states
    typedef enum logic [2:0] {
        PSR_IDLE  = 3'b000,
        PSR_ADDR  = 3'b001,
        PSR_WAIT  = 3'b010,
        PSR_STORE = 3'b011,
        PSR_DONE  = 3'b100
    } psr_state_t;

endpackage

// ---- rtl/psr_sync.sv ----
// two-stage synchroniser, one per bit of a bus
// assumes the bus is held stable long enough for all bits to settle
`timescale 1ns/1ns
module psr_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // first stage is read only by the second stage
    genvar b;
    generate
        for (b = 0; b < WIDTH; b = b + 1) begin : g_bit
            logic meta;   // first stage, metastability catcher
            always_ff @(posedge mclk or posedge sys_rst) begin
                if (sys_rst) begin
                    meta        <= 1'b0;
                    sync_out[b] <= 1'b0;
                end else begin
                    meta        <= async_in[b];
                    sync_out[b] <= meta;
                end
            end
        end
    endgenerate

endmodule

// ---- rtl/psr_readout.sv ----
// production signature readout: a read-only byte bank loaded from fuses
// assumes a fuse array on pins that answers a held address within a
// fixed access time, and a one-cycle strobe register port on mclk
`timescale 1ns/1ns
module psr_readout
    import psr_pkg::*;
#(
    parameter int LOAD_WAIT = psr_pkg::LOAD_WAIT_CYC  // wait-state cycles; address to capture takes LOAD_WAIT + 2
) (
    input  wire logic                          mclk,
    input  wire logic                          sys_rst,
    input  wire logic [psr_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [psr_pkg::DATA_W-1:0]    reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [psr_pkg::DATA_W-1:0]    reg_rdata,
    output logic      [psr_pkg::ADDR_W-1:0]    fuse_addr,
    output logic                               fuse_rd,
    input  wire logic [psr_pkg::DATA_W-1:0]    fuse_data,
    output logic                               load_done,
    output logic      [psr_pkg::SERIAL_W-1:0]  serial_id
);

    import psr_pkg::*;

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    psr_state_t              state;            // load sequencer state
    logic [IDX_W-1:0]        load_idx;         // entry being fetched
    logic [WAIT_W-1:0]       wait_cnt;         // settle counter
    logic                    load_req;         // pending load request
    logic [DATA_W-1:0]       fuse_sync;        // fuse data after two flops
    logic [DATA_W-1:0]       shadow [0:ENTRY_COUNT-1]; // captured bytes
    logic [ENTRY_COUNT-1:0]  bank_hit;         // address matches an entry
    logic                    any_hit;          // address inside the bank
    logic                    ctrl_hit;         // address is the control reg
    logic                    status_hit;       // address is the status reg
    logic [DATA_W-1:0]       bank_rd_value;    // selected bank byte
    logic [DATA_W-1:0]       status_value;     // assembled status byte
    logic                    wr_ignored;       // sticky: bank write dropped
    logic                    unmapped;         // sticky: access hit nothing
    logic                    ctrl_wr;          // write to control register
    logic                    reload_cmd;       // software asked for reload
    logic                    clr_wr_cmd;       // clear write-ignored flag
    logic                    clr_map_cmd;      // clear unmapped flag
    logic                    store_now;        // capture cycle for load_idx
    logic                    taking_req;       // sequencer accepts request
    logic                    bank_wr;          // write aimed at the bank
    logic                    stray_access;     // access at no location

    localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(LOAD_WAIT - 1);

    // ---------------------------------------------------------------
    // fuse data comes from pins, so it crosses two flops first
    // ---------------------------------------------------------------
    psr_sync #(
        .WIDTH    (DATA_W)
    ) u_fuse_sync (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .async_in (fuse_data),
        .sync_out (fuse_sync)
    );

    // ---------------------------------------------------------------
    // address decode, shared by read and write paths
    // ---------------------------------------------------------------

    // one comparator per bank entry
    genvar e;
    generate
        for (e = 0; e < ENTRY_COUNT; e = e + 1) begin : g_hit
            assign bank_hit[e] = (reg_addr == SIG_OFFS[e]);
        end
    endgenerate

    assign any_hit    = |bank_hit;
    assign ctrl_hit   = (reg_addr == OFF_CTRL);
    assign status_hit = (reg_addr == OFF_STATUS);

    // command decode from the control register write
    assign ctrl_wr     = reg_wr && ctrl_hit;
    assign reload_cmd  = ctrl_wr && reg_wdata[CTRL_RELOAD];
    assign clr_wr_cmd  = ctrl_wr && reg_wdata[CTRL_CLR_WR];
    assign clr_map_cmd = ctrl_wr && reg_wdata[CTRL_CLR_MAP];

    // bank writes are dropped but remembered in status
    assign bank_wr = reg_wr && any_hit;

    // any strobe that lands on no location at all
    assign stray_access = (reg_wr || reg_rd) && !any_hit
                          && !ctrl_hit && !status_hit;

    // sequencer handshake terms
    assign store_now  = (state == PSR_STORE);
    assign taking_req = load_req
                        && ((state == PSR_IDLE) || (state == PSR_DONE));

    // ---------------------------------------------------------------
    // load request: raised at reset so the bank fills by itself,
    // raised again by software through the control register
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            load_req <= 1'b1;                  // fill once after reset
        end else if (reload_cmd) begin
            load_req <= 1'b1;                  // request wins over take
        end else if (taking_req) begin
            load_req <= 1'b0;                  // consumed by sequencer
        end
    end

    // ---------------------------------------------------------------
    // load sequencer: walks every entry, holds the fuse address long
    // enough for access time plus the synchroniser, then captures
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state    <= PSR_IDLE;
            load_idx <= '0;
            wait_cnt <= '0;
        end else begin
            case (state)
                PSR_IDLE: begin
                    // nothing loaded yet; wait for the first request
                    if (load_req) begin
                        load_idx <= '0;
                        state    <= PSR_ADDR;
                    end
                end
                PSR_ADDR: begin
                    // address is presented this cycle, start settling
                    wait_cnt <= '0;
                    state    <= PSR_WAIT;
                end
                PSR_WAIT: begin
                    // data is only trusted once it has crossed both flops
                    if (wait_cnt == WAIT_LAST) begin
                        state <= PSR_STORE;
                    end else begin
                        wait_cnt <= wait_cnt + 1'b1;
                    end
                end
                PSR_STORE: begin
                    // byte captured this cycle; move on or finish
                    if (load_idx == IDX_LAST) begin
                        state <= PSR_DONE;
                    end else begin
                        load_idx <= load_idx + 1'b1;
                        state    <= PSR_ADDR;
                    end
                end
                PSR_DONE: begin
                    // bank is valid; a reload walks it all again
                    if (load_req) begin
                        load_idx <= '0;
                        state    <= PSR_ADDR;
                    end
                end
                default: begin
                    // illegal code, recover to idle and wait for a load request
                    state    <= PSR_IDLE;
                    load_idx <= '0;
                    wait_cnt <= '0;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // fuse port: address and read enable straight from flops
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            fuse_addr <= '0;
            fuse_rd   <= 1'b0;
        end else if (taking_req) begin
            fuse_addr <= SIG_OFFS[0];          // first entry of the walk
            fuse_rd   <= 1'b1;
        end else if (store_now && load_idx != IDX_LAST) begin
            fuse_addr <= SIG_OFFS[load_idx + 1'b1];  // next entry
            fuse_rd   <= 1'b1;
        end else if (store_now) begin
            fuse_rd   <= 1'b0;                 // walk finished
        end
    end

    // ---------------------------------------------------------------
    // shadow bytes: one capture register per entry; the mask forces
    // the bits that do not exist to zero whatever the fuses hold,
    // and no software write path reaches these registers
    // ---------------------------------------------------------------
    generate
        for (e = 0; e < ENTRY_COUNT; e = e + 1) begin : g_shadow
            always_ff @(posedge mclk or posedge sys_rst) begin
                if (sys_rst) begin
                    shadow[e] <= BYTE_ZERO;
                end else if (store_now && load_idx == IDX_W'(e)) begin
                    shadow[e] <= fuse_sync & SIG_MASK[e];
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // bank read mux; trim bytes are offered as-is, copying them into
    // the analog and clock blocks is left to software
    // ---------------------------------------------------------------
    always_comb begin
        bank_rd_value = BYTE_ZERO;
        for (int i = 0; i < ENTRY_COUNT; i++) begin
            if (bank_hit[i]) begin
                bank_rd_value = shadow[i];
            end
        end
    end

    // status byte assembled from live state and sticky flags
    always_comb begin
        status_value               = BYTE_ZERO;
        status_value[ST_DONE]      = load_done;
        status_value[ST_WR_IGN]    = wr_ignored;
        status_value[ST_UNMAP]     = unmapped;
        status_value[ST_BUSY]      = (state != PSR_IDLE) && (state != PSR_DONE);
    end

    // ---------------------------------------------------------------
    // read data: valid only in the cycle after the read strobe,
    // zero at every other time so a stale byte never lingers
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= BYTE_ZERO;
        end else if (reg_rd && any_hit) begin
            reg_rdata <= bank_rd_value;
        end else if (reg_rd && status_hit) begin
            reg_rdata <= status_value;
        end else begin
            reg_rdata <= BYTE_ZERO;            // control, unmapped or idle
        end
    end

    // ---------------------------------------------------------------
    // sticky flags: a new event in the clearing cycle survives
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ignored <= 1'b0;
        end else if (bank_wr) begin
            wr_ignored <= 1'b1;
        end else if (clr_wr_cmd) begin
            wr_ignored <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            unmapped <= 1'b0;
        end else if (stray_access) begin
            unmapped <= 1'b1;
        end else if (clr_map_cmd) begin
            unmapped <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // load complete: high from the last capture until a reload starts
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            load_done <= 1'b0;
        end else if (taking_req) begin
            load_done <= 1'b0;                 // bank is being refreshed
        end else if (store_now && load_idx == IDX_LAST) begin
            load_done <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // die identity word for system use: wafer, then X, then Y; the
    // lot number lives outside this bank and is joined by software
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            serial_id <= '0;
        end else begin
            serial_id <= {shadow[IDX_WAFER],
                          shadow[IDX_X_HI], shadow[IDX_X_LO],
                          shadow[IDX_Y_HI], shadow[IDX_Y_LO]};
        end
    end

endmodule

// ---- dv/psr_readout_monitor.sv ----
// checker for the production signature readout bank, watching its ports
// assumes it is bound onto psr_readout: one clock mclk, async reset sys_rst
`timescale 1ns/1ns
module psr_readout_monitor
    import psr_pkg::*;
#(
    parameter int LOAD_WAIT = 4  // wait-state cycles; fuse address to capture takes LOAD_WAIT + 2
) (
    input wire logic                          mclk,
    input wire logic                          sys_rst,
    input wire logic [psr_pkg::ADDR_W-1:0]    reg_addr,
    input wire logic [psr_pkg::DATA_W-1:0]    reg_wdata,
    input wire logic                          reg_wr,
    input wire logic                          reg_rd,
    input wire logic [psr_pkg::DATA_W-1:0]    reg_rdata,
    input wire logic [psr_pkg::ADDR_W-1:0]    fuse_addr,
    input wire logic                          fuse_rd,
    input wire logic [psr_pkg::DATA_W-1:0]    fuse_data,
    input wire logic                          load_done,
    input wire logic [psr_pkg::SERIAL_W-1:0]  serial_id
);
    import psr_pkg::*;
    logic [5:0] prev_addr;  // fuse address one cycle back
    logic [7:0] gap_cnt;    // cycles since the fuse address last moved
    logic [5:0] exp_next;   // entry expected after prev_addr
    logic       bank_hit;   // register address is a listed location

    // saturating gap counter, so a long idle spell never wraps into a match
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_addr <= 6'h00;
            gap_cnt   <= 8'h00;
        end else begin
            prev_addr <= fuse_addr;
            if (fuse_addr != prev_addr) begin
                gap_cnt <= 8'h01;
            end else if (gap_cnt != 8'hFF) begin
                gap_cnt <= gap_cnt + 8'h01;
            end
        end
    end

    // walk order: skip the holes between listed offsets
    always_comb begin
        case (prev_addr)
            6'h10: exp_next = 6'h12;
            6'h15: exp_next = 6'h1A;
            6'h1C: exp_next = 6'h20;
            6'h21: exp_next = 6'h24;
            6'h25: exp_next = 6'h2E;
            default: exp_next = prev_addr + 6'h01;
        endcase
        bank_hit = reg_addr inside {6'h10, 6'h12, 6'h13, 6'h14, 6'h15, 6'h1A, 6'h1B,
            6'h1C, 6'h20, 6'h21, 6'h24, 6'h25, 6'h2E, 6'h2F, 6'h3E, 6'h3F};
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    a_wafer_top_zero: assert property ($past(reg_rd) && $past(reg_addr) == 6'h10 |-> reg_rdata[7:5] == 3'b000)
        else $error("wafer byte top bits not zero");
    a_temp_top_zero: assert property ($past(reg_rd) && $past(reg_addr) == 6'h2F |-> reg_rdata[7:4] == 4'h0)
        else $error("temperature high byte top bits not zero");
    a_unmapped_zero: assert property (reg_rd && !bank_hit |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_write_silent: assert property (reg_wr |=> reg_rdata == 8'h00)
        else $error("write produced read data");
    a_serial_top: assert property (load_done |-> serial_id[39:37] == 3'b000)
        else $error("serial wafer field top bits not zero");
    a_entry_period: assert property (fuse_rd && $past(fuse_rd) && fuse_addr != prev_addr
        |-> gap_cnt == LOAD_WAIT + 2)
        else $error("fuse entry period wrong");
    a_fuse_order: assert property (fuse_rd && $past(fuse_rd) && fuse_addr != prev_addr
        |-> fuse_addr == exp_next)
        else $error("fuse entries out of order");
    a_done_last: assert property ($rose(load_done) |-> !fuse_rd && $past(fuse_addr) == 6'h2F)
        else $error("load finished before last entry");
    a_reload_start: assert property (reg_wr && reg_addr == 6'h3E && reg_wdata[0]
        |-> ##2 fuse_rd && !load_done && fuse_addr == 6'h10)
        else $error("reload did not restart walk");
    a_load_bound: assert property ($rose(fuse_rd) |-> ##[60:100] load_done)
        else $error("load did not finish in time");

    c_reload: cover property (reg_wr && reg_addr == 6'h3E && reg_wdata[0]);
    c_unmapped: cover property (reg_rd && !bank_hit);
    c_done: cover property ($rose(load_done));
endmodule

bind psr_readout psr_readout_monitor #(.LOAD_WAIT(LOAD_WAIT)) mon_u (
    .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fuse_addr(fuse_addr),
    .fuse_rd(fuse_rd), .fuse_data(fuse_data), .load_done(load_done), .serial_id(serial_id)
);

// ---- dv/psr_readout_test.sv ----
// self-checking bench for the signature readout bank
// assumes the bench plays the fuse array and the register bus master
`timescale 1ns/1ns
module psr_readout_test;
    import psr_pkg::*;
    logic                mclk;
    logic                sys_rst;
    logic [ADDR_W-1:0]   reg_addr;
    logic [DATA_W-1:0]   reg_wdata;
    logic                reg_wr;
    logic                reg_rd;
    logic [DATA_W-1:0]   reg_rdata;
    logic [ADDR_W-1:0]   fuse_addr;
    logic                fuse_rd;
    logic [DATA_W-1:0]   fuse_data;
    logic                load_done;
    logic [SERIAL_W-1:0] serial_id;
    int                  err_total;
    int                  samples_checked;
    int                  cyc;
    logic [7:0]          key;  // fuse content pattern, changed before a reload
    logic [5:0] offs [14] = '{6'h10, 6'h12, 6'h13, 6'h14, 6'h15, 6'h1A, 6'h1B,
                              6'h1C, 6'h20, 6'h21, 6'h24, 6'h25, 6'h2E, 6'h2F};
    logic [7:0] msk  [14] = '{8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                              8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F};

    psr_readout #(.LOAD_WAIT(4)) dut_u (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .fuse_addr(fuse_addr), .fuse_rd(fuse_rd), .fuse_data(fuse_data),
        .load_done(load_done), .serial_id(serial_id));

    // expected byte of entry i: fuse pattern with absent bits cleared
    function automatic logic [7:0] exp_byte(input int i);
        return (8'hA5 ^ {2'b00, offs[i]} ^ key) & msk[i];
    endfunction

    always #25 mclk = ~mclk;

    // fuse array: unselected, the data lines wander instead of holding
    always @(posedge mclk) begin
        if (fuse_rd) begin
            fuse_data <= 8'hA5 ^ {2'b00, fuse_addr} ^ key;
        end else begin
            fuse_data <= ~fuse_data;
        end
    end

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            print_verdict();
        end
    end

    task automatic chk(input logic [SERIAL_W-1:0] got, input logic [SERIAL_W-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic wait_done();
        for (int n = 0; n < 200 && load_done !== 1'b1; n++) @(posedge mclk);
        #1 chk(load_done, 1'b1);
    endtask

    // every bank byte reads back its masked production value
    task automatic t_read_bank();
        logic [7:0] d;
        for (int i = 0; i < 14; i++) begin
            rd(offs[i], d);
            chk(d, exp_byte(i));
        end
        @(posedge mclk);
        #1 chk(reg_rdata, 8'h00);
        chk(serial_id, {exp_byte(0), exp_byte(2), exp_byte(1), exp_byte(4), exp_byte(3)});
        $display("bank read done");
    endtask

    // writes to the bank leave it untouched and raise the sticky flag
    task automatic t_write_ignore();
        logic [7:0] d;
        for (int i = 0; i < 14; i++) wr(offs[i], ~exp_byte(i));
        t_read_bank();
        rd(6'h3F, d);
        chk(d[1], 1'b1);
        wr(6'h3E, 8'h02);
        rd(6'h3F, d);
        chk(d[1], 1'b0);
        $display("write ignore done");
    endtask

    // holes in the map read zero and flag themselves
    task automatic t_unmapped();
        logic [7:0] d;
        rd(6'h11, d);
        chk(d, 8'h00);
        rd(6'h00, d);
        chk(d, 8'h00);
        rd(6'h3F, d);
        chk(d[2], 1'b1);
        wr(6'h3E, 8'h04);
        rd(6'h3F, d);
        chk(d[2], 1'b0);
        $display("unmapped done");
    endtask

    // reload picks up new fuse content; a reset in mid-walk clears outputs
    task automatic t_reload();
        key = 8'h3C;
        wr(6'h3E, 8'h01);
        // request is latched on the strobe edge and taken one edge later
        @(posedge mclk);
        #1 chk(load_done, 1'b0);
        chk(fuse_rd, 1'b1);
        wait_done();
        t_read_bank();
        key = 8'h5A;
        wr(6'h3E, 8'h01);
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b1;
        #1 chk(fuse_rd, 1'b0);
        chk(load_done, 1'b0);
        chk(reg_rdata, 8'h00);
        @(posedge mclk);
        sys_rst <= 1'b0;
        wait_done();
        t_read_bank();
        $display("reload done");
    endtask

    task automatic print_verdict();
        $display("checked %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        sys_rst = 1'b1;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        fuse_data = 8'h00;
        key = 8'h00;
        err_total = 0;
        samples_checked = 0;
        cyc = 0;
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        wait_done();
        t_read_bank();
        t_write_ignore();
        t_unmapped();
        t_reload();
        print_verdict();
    end
endmodule
